/* File: src/pfs_sequencer.sv */
// Purpose: Firmware-driven read and self-programming write of program flash.
// Assumes: One clock per instruction cycle; APB register access from the core.
// Notes: coreStall holds the core during a program write.
// Functional notes
// - Read fetches over the next two cycles; data valid after the second.
// - Data registers keep last fetched word until new read or firmware write.
// - Core stalls during a program write and resumes where it stopped.
// - Clock and peripherals keep running; interrupts stay pending during stall.
// - Cleared write-protect configuration blocks every program write.
// - Write-start is accepted only if write-enable was set earlier.
// - Clearing write-enable during a write does not abort it.
// - Two setup cycles follow write-start before the stall begins.
// - Write end clears write-start and sets sticky write-done flag.
// - Program word is 14 bits split across high and low data registers.
// - No automatic verify after a write.
// - 13-bit word address wraps onto the implemented space.
// - Reset clears write-enable; power-up timer blocks writes until it expires.
`timescale 1ns/1ps
`default_nettype none
module pfs_sequencer #(
   parameter int MEM_DEPTH = 256,
   parameter int WRITE_CYCLES = pfs_pkg::WRITE_CYCLES,
   parameter int POWERUP_CYCLES = pfs_pkg::POWERUP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pfs_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic programWriteAllowCfg,
   input wire logic powerupTimerEnable,
   output logic coreStall,
   output logic irq
);
   import pfs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] nvmAddrLow;
   logic [4:0] nvmAddrHigh;
   logic [7:0] nvmWordLow;
   logic [5:0] nvmWordHigh;
   logic writeEnable;
   logic writeStart;
   logic readStart;
   logic programSpaceSelect;
   logic [1:0] unlockStep;
   logic [IRQ_W-1:0] irqStatus;
   logic [IRQ_W-1:0] irqMask;
   pfs_state_t state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] powerupCnt;
   logic powerupDone;
   logic cfgMeta;
   logic cfgSync;
   logic [1:0] timerSync;
   logic [ADDR_W-1:0] wordAddr;
   logic [WORD_W-1:0] arrayData;
   logic arrayWrite;
   logic wrAccess;
   logic rdAccess;
   logic ctlWrite;
   logic startRead;
   logic startWrite;
   logic readDone;
   logic progDone;
   logic [CNT_W-1:0] writeLast;
   logic [CNT_W-1:0] powerupLast;

   function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [PADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   assign writeLast = CNT_W'(WRITE_CYCLES - 1);
   assign powerupLast = CNT_W'(POWERUP_CYCLES - 1);
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wrAccess = psel && penable && pwrite;
   assign rdAccess = psel && penable && !pwrite;
   assign ctlWrite = wrAccess && hit(paddr, OFF_CONTROL);
   assign wordAddr = {nvmAddrHigh, nvmAddrLow};
   assign readDone = (state == PFS_READ) && (cnt == CNT_W'(READ_SLOTS - 1));
   assign progDone = (state == PFS_PROG) && (cnt == writeLast);
   assign arrayWrite = progDone;

   // Read starts on a set of the read bit while idle with program space chosen.
   assign startRead = ctlWrite && pwdata[CTL_READ] && programSpaceSelect
      && (state == PFS_IDLE);
   // Unlock complete, write-enable already set, protection open, timer done.
   assign startWrite = ctlWrite && pwdata[CTL_WRITE] && writeEnable
      && (unlockStep == 2'd2) && programSpaceSelect
      && cfgSync && powerupDone
      && (state == PFS_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // The configuration straps come from outside the block. The timer strap resets to
   // enabled so that no write slips through before its real level has been sampled.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cfgMeta <= 1'b0;
         cfgSync <= 1'b0;
         timerSync <= 2'b11;
      end else begin
         cfgMeta <= programWriteAllowCfg;
         cfgSync <= cfgMeta;
         timerSync <= {timerSync[0], powerupTimerEnable};
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         powerupCnt <= '0;
         powerupDone <= 1'b0;
      end else if (!timerSync[1]) begin
         powerupDone <= 1'b1;
      end else if (!powerupDone) begin
         if (powerupCnt == powerupLast) begin
            powerupDone <= 1'b1;
         end else begin
            powerupCnt <= powerupCnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Unlock tracker: 0 idle, 1 saw first key, 2 saw second key.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         unlockStep <= 2'd0;
      end else if (wrAccess) begin
         if (hit(paddr, OFF_UNLOCK) && pwdata[7:0] == UNLOCK_FIRST && unlockStep == 2'd0) begin
            unlockStep <= 2'd1;
         end else if (hit(paddr, OFF_UNLOCK) && pwdata[7:0] == UNLOCK_SECOND
               && unlockStep == 2'd1) begin
            unlockStep <= 2'd2;
         end else begin
            unlockStep <= 2'd0;
         end
      end else if (rdAccess) begin
         unlockStep <= 2'd0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         nvmAddrLow <= '0;
         nvmAddrHigh <= '0;
      end else if (wrAccess && hit(paddr, OFF_ADDR_LOW)) begin
         nvmAddrLow <= pwdata[7:0];
      end else if (wrAccess && hit(paddr, OFF_ADDR_HIGH)) begin
         nvmAddrHigh <= pwdata[4:0];
      end
   end

   // Firmware writes and read results share the word registers.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         nvmWordLow <= '0;
         nvmWordHigh <= '0;
      end else if (readDone) begin
         nvmWordLow <= arrayData[7:0];
         nvmWordHigh <= arrayData[13:8];
      end else if (wrAccess && hit(paddr, OFF_WORD_LOW)) begin
         nvmWordLow <= pwdata[7:0];
      end else if (wrAccess && hit(paddr, OFF_WORD_HIGH)) begin
         nvmWordHigh <= pwdata[5:0];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         writeEnable <= 1'b0;
         programSpaceSelect <= 1'b0;
      end else if (ctlWrite) begin
         // Clearing this only blocks new starts; it never reaches a write already in PFS_SETUP or PFS_PROG.
         writeEnable <= pwdata[CTL_WR_ENABLE];
         programSpaceSelect <= pwdata[CTL_SPACE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= PFS_IDLE;
         cnt <= '0;
         readStart <= 1'b0;
         writeStart <= 1'b0;
      end else begin
         case (state)
            PFS_IDLE: begin
               cnt <= '0;
               if (startWrite) begin
                  writeStart <= 1'b1;
                  state <= PFS_SETUP;
               end else if (startRead) begin
                  readStart <= 1'b1;
                  state <= PFS_READ;
               end
            end
            PFS_READ: begin
               if (readDone) begin
                  readStart <= 1'b0;
                  cnt <= '0;
                  state <= PFS_IDLE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            PFS_SETUP: begin
               if (cnt == CNT_W'(SETUP_SLOTS - 1)) begin
                  cnt <= '0;
                  state <= PFS_PROG;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            PFS_PROG: begin
               if (progDone) begin
                  writeStart <= 1'b0;
                  cnt <= '0;
                  state <= PFS_IDLE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: begin
               state <= PFS_IDLE;
            end
         endcase
      end
   end

   // Only the core is held; this block and others keep their clock.
   assign coreStall = (state == PFS_PROG);

   ////////////////////////////////////////////////////////////////////////
   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irqStatus <= '0;
         irqMask <= '0;
      end else begin
         for (int i = 0; i < IRQ_W; i++) begin
            if ((i == IRQ_DONE && progDone) || (i == IRQ_READ && readDone)) begin
               irqStatus[i] <= 1'b1;
            end else if (wrAccess && hit(paddr, OFF_IRQ_STATUS) && pwdata[i]) begin
               irqStatus[i] <= 1'b0;
            end
         end
         if (wrAccess && hit(paddr, OFF_IRQ_MASK)) begin
            irqMask <= pwdata[IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irqStatus & irqMask);

   always_comb begin
      prdata = '0;
      case (paddr)
         OFF_ADDR_LOW: prdata[7:0] = nvmAddrLow;
         OFF_ADDR_HIGH: prdata[4:0] = nvmAddrHigh;
         OFF_WORD_LOW: prdata[7:0] = nvmWordLow;
         OFF_WORD_HIGH: prdata[5:0] = nvmWordHigh;
         OFF_CONTROL: begin
            prdata[CTL_READ] = readStart;
            prdata[CTL_WRITE] = writeStart;
            prdata[CTL_WR_ENABLE] = writeEnable;
            prdata[CTL_SPACE] = programSpaceSelect;
         end
         OFF_IRQ_STATUS: prdata[IRQ_W-1:0] = irqStatus;
         OFF_IRQ_MASK: prdata[IRQ_W-1:0] = irqMask;
         default: prdata = '0;
      endcase
   end

   // The array is written as given; no read-back compare is done.
   pfs_flash_array #(
      .DEPTH(MEM_DEPTH),
      .ADDR_W(ADDR_W),
      .WORD_W(WORD_W)
   ) u_array (
      .ref_clk(ref_clk),
      .reset(reset),
      .addr(wordAddr),
      .write_enable(arrayWrite),
      .wrData({nvmWordHigh, nvmWordLow}),
      .rdData(arrayData)
   );

   ////////////////////////////////////////////////////////////////////////
   sequence setupSeq;
      state == PFS_SETUP [*2];
   endsequence

   enable_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(writeStart) |-> $past(writeEnable) && $past(unlockStep) == 2'd2)
      else $error("write started without prior enable and unlock");
   protect_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(writeStart) |-> $past(cfgSync))
      else $error("write started while protected");
   setup_stall_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(writeStart) |-> setupSeq ##1 coreStall)
      else $error("stall did not follow two setup cycles");
   read_time_a: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(readStart) |-> ##1 readDone ##1 !readStart)
      else $error("read did not finish in two cycles");
   read_data_a: assert property (@(posedge ref_clk) disable iff (reset)
      readDone |=> {nvmWordHigh, nvmWordLow} == $past(arrayData))
      else $error("read result not loaded into word registers");
   done_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
      progDone |=> !writeStart && irqStatus[IRQ_DONE] && !coreStall)
      else $error("write end did not clear start and set flag");
   no_abort_a: assert property (@(posedge ref_clk) disable iff (reset)
      coreStall && !progDone |=> coreStall)
      else $error("write aborted early");
   word_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      !readDone && !(wrAccess && (hit(paddr, OFF_WORD_LOW) || hit(paddr, OFF_WORD_HIGH)))
      |=> $stable(nvmWordLow) && $stable(nvmWordHigh))
      else $error("data registers changed without cause");
   unlock_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
      rdAccess |=> unlockStep == 2'd0)
      else $error("unlock tracker not reset on stray access");
   stall_pending_a: assert property (@(posedge ref_clk) disable iff (reset)
      coreStall |=> $stable(irqStatus[IRQ_READ]) && $stable(irqMask))
      else $error("pending interrupt state changed during stall");
   powerup_a: assert property (@(posedge ref_clk) disable iff (reset)
      !powerupDone |-> !$rose(writeStart))
      else $error("write before power-up timer expired");
endmodule : pfs_sequencer
`default_nettype wire

/* File: pkg/pfs_pkg.sv */
// Purpose: Constants for the program flash read/write sequencer.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Offsets, field positions, reset values and timing counts live here.
package pfs_pkg;
   localparam int ADDR_W = 13;
   localparam int WORD_W = 14;
   localparam int PADDR_W = 8;
   localparam logic [PADDR_W-1:0] OFF_ADDR_LOW = 8'h00;
   localparam logic [PADDR_W-1:0] OFF_ADDR_HIGH = 8'h04;
   localparam logic [PADDR_W-1:0] OFF_WORD_LOW = 8'h08;
   localparam logic [PADDR_W-1:0] OFF_WORD_HIGH = 8'h0C;
   localparam logic [PADDR_W-1:0] OFF_CONTROL = 8'h10;
   localparam logic [PADDR_W-1:0] OFF_UNLOCK = 8'h14;
   localparam logic [PADDR_W-1:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [PADDR_W-1:0] OFF_IRQ_MASK = 8'h1C;
   // Control register fields.
   localparam int CTL_READ = 0;
   localparam int CTL_WRITE = 1;
   localparam int CTL_WR_ENABLE = 2;
   localparam int CTL_SPACE = 7;
   // Interrupt status fields.
   localparam int IRQ_DONE = 0;
   localparam int IRQ_READ = 1;
   localparam int IRQ_W = 2;
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // Timing: one instruction cycle is one clock here.
   localparam int CLK_MHZ = 50;
   localparam int READ_SLOTS = 2;
   localparam int SETUP_SLOTS = 2;
   localparam int WRITE_TIME_US = 2000;
   localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
   localparam int POWERUP_TIME_US = 72000;
   localparam int POWERUP_CYCLES = POWERUP_TIME_US * CLK_MHZ;
   localparam int CNT_W = 24;
   typedef enum {PFS_IDLE, PFS_READ, PFS_SETUP, PFS_PROG} pfs_state_t;
endpackage : pfs_pkg

/* File: src/pfs_flash_array.sv */
// Purpose: Program flash array model in flip-flops, one word per address.
// Assumes: Single clock, write port and registered read port.
// Notes: Address wraps onto the implemented depth by dropping upper bits.
`timescale 1ns/1ps
`default_nettype none
module pfs_flash_array #(
   parameter int DEPTH = 256,
   parameter int ADDR_W = 13,
   parameter int WORD_W = 14
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic write_enable,
   input wire logic [WORD_W-1:0] wrData,
   output logic [WORD_W-1:0] rdData
);
   localparam int IDX_W = $clog2(DEPTH);
   logic [WORD_W-1:0] mem [DEPTH];
   logic [IDX_W-1:0] idx;

   // Upper bits ignored so that addresses above depth fold back.
   assign idx = addr[IDX_W-1:0];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= {WORD_W{1'b1}};
         end
      end else if (write_enable) begin
         mem[idx] <= wrData;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdData <= '0;
      end else begin
         rdData <= mem[idx];
      end
   end
endmodule : pfs_flash_array
`default_nettype wire

/* File: dv/pfs_core_model.sv */
// Purpose: Firmware core model that reaches the sequencer over APB.
// Assumes: One transfer at a time, changes made just after a rising edge.
// Notes: Holds off starting a transfer while the core is stalled by a program write.
`timescale 1ns/1ps
`default_nettype none
module pfs_core_model (
   input wire logic ref_clk,
   input wire logic coreStall,
   input wire logic pready,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [pfs_pkg::PADDR_W-1:0] paddr,
   output logic [31:0] pwdata
);
   import pfs_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end
   ////////////////////////////////////////////////////////////
   // Released address and data lines show the inverse of their last value.
   task automatic xfer(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge ref_clk);
      while (coreStall !== 1'b0) begin
         @(posedge ref_clk);
      end
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   task automatic nop(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : nop
endmodule : pfs_core_model
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the program flash sequencer.
// Assumes: Short write and power-up counts set through parameters.
// Notes: Each scenario is one task; expectations come from constants.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
   end \
end
module testbench;
   import pfs_pkg::*;
   localparam int WCYC = 8;
   localparam int PCYC = 60;
   logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic cfgAllow, timerEn, coreStall, irq;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   pfs_sequencer #(.MEM_DEPTH(256), .WRITE_CYCLES(WCYC), .POWERUP_CYCLES(PCYC))
         pfs_sequencer_inst (.ref_clk(ref_clk), .reset(reset), .psel(psel),
         .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
         .prdata(prdata), .pready(pready), .pslverr(pslverr),
         .programWriteAllowCfg(cfgAllow), .powerupTimerEnable(timerEn),
         .coreStall(coreStall), .irq(irq));
   pfs_core_model pfs_core_model_inst (.ref_clk(ref_clk), .coreStall(coreStall),
         .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
         .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] unused;
      pfs_core_model_inst.xfer(1'b1, a, d, unused);
   endtask : wr
   task automatic rd(input logic [PADDR_W-1:0] a, output logic [31:0] r);
      pfs_core_model_inst.xfer(1'b0, a, 32'h0000_0000, r);
   endtask : rd
   task automatic settle();
      @(posedge ref_clk);
      #1;
   endtask : settle
   task automatic setAddr(input logic [12:0] a);
      wr(OFF_ADDR_LOW, {24'h00_0000, a[7:0]});
      wr(OFF_ADDR_HIGH, {27'h000_0000, a[12:8]});
   endtask : setAddr
   // Mode 1 sets write-enable with write-start, mode 2 breaks the unlock pair.
   task automatic doWrite(input logic [12:0] a, input logic [13:0] w, input int mode,
         input logic ok);
      int n;
      wr(OFF_IRQ_STATUS, 32'h0000_0003);
      setAddr(a);
      wr(OFF_WORD_LOW, {24'h00_0000, w[7:0]});
      wr(OFF_WORD_HIGH, {26'h000_0000, w[13:8]});
      wr(OFF_CONTROL, (mode == 1) ? 32'h0000_0080 : 32'h0000_0084);
      wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_FIRST});
      if (mode == 2) rd(OFF_CONTROL, q);
      wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_SECOND});
      wr(OFF_CONTROL, 32'h0000_0086);
      #1;
      `CHK(coreStall, 1'b0)
      settle();
      `CHK(coreStall, 1'b0)
      settle();
      `CHK(coreStall, ok)
      n = 0;
      while (coreStall === 1'b1 && n < 100) begin
         settle();
         n++;
      end
      `CHK(n, ok ? WCYC : 0)
      rd(OFF_CONTROL, q);
      `CHK(q, 32'h0000_0084)
      rd(OFF_IRQ_STATUS, q);
      `CHK(q[IRQ_DONE], ok)
      wr(OFF_CONTROL, 32'h0000_0080);
   endtask : doWrite
   task automatic doRead(input logic [12:0] a, input logic [13:0] w);
      logic [31:0] lo;
      setAddr(a);
      wr(OFF_CONTROL, 32'h0000_0080);
      wr(OFF_CONTROL, 32'h0000_0081);
      pfs_core_model_inst.nop(2);
      rd(OFF_WORD_LOW, lo);
      rd(OFF_WORD_HIGH, q);
      `CHK({q[5:0], lo[7:0]}, w)
   endtask : doRead
   ////////////////////////////////////////////////////////////
   task automatic tPowerup();
      rd(OFF_CONTROL, q);
      `CHK(q, 32'h0000_0000)
      `CHK(irq, 1'b0)
      doWrite(13'h0005, 14'h1234, 0, 1'b0);
      repeat (PCYC) @(posedge ref_clk);
      doRead(13'h0005, 14'h3FFF);
   endtask : tPowerup
   task automatic tWriteRead();
      doWrite(13'h0005, 14'h2A5C, 0, 1'b1);
      doRead(13'h0005, 14'h2A5C);
      doRead(13'h0105, 14'h2A5C);
      doRead(13'h0006, 14'h3FFF);
      rd(OFF_WORD_LOW, q);
      `CHK(q, 32'h0000_00FF)
      wr(OFF_WORD_LOW, 32'h0000_0033);
      rd(OFF_WORD_LOW, q);
      `CHK(q, 32'h0000_0033)
   endtask : tWriteRead
   task automatic tReject();
      doWrite(13'h0007, 14'h0001, 1, 1'b0);
      doWrite(13'h0007, 14'h0001, 2, 1'b0);
      @(posedge ref_clk);
      cfgAllow <= 1'b0;
      doWrite(13'h0007, 14'h0001, 0, 1'b0);
      @(posedge ref_clk);
      cfgAllow <= 1'b1;
      doRead(13'h0007, 14'h3FFF);
   endtask : tReject
   task automatic tIrq();
      wr(OFF_IRQ_MASK, 32'h0000_0000);
      doWrite(13'h0009, 14'h0FF0, 0, 1'b1);
      `CHK(irq, 1'b0)
      wr(OFF_IRQ_MASK, 32'h0000_0001);
      settle();
      `CHK(irq, 1'b1)
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      settle();
      `CHK(irq, 1'b0)
      doRead(13'h0009, 14'h0FF0);
      wr(OFF_IRQ_MASK, 32'h0000_0002);
      settle();
      `CHK(irq, 1'b1)
      rd(OFF_IRQ_STATUS, q);
      `CHK(q, 32'h0000_0002)
      wr(OFF_IRQ_STATUS, 32'h0000_0002);
      settle();
      `CHK(irq, 1'b0)
   endtask : tIrq
   // A stray write to an unmapped offset between the two keys must break the unlock.
   task automatic tMap();
      wr(OFF_CONTROL, 32'h0000_0084);
      wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_FIRST});
      wr(8'h20, 32'hFFFF_FFFF);
      wr(OFF_UNLOCK, {24'h00_0000, UNLOCK_SECOND});
      wr(OFF_CONTROL, 32'h0000_0086);
      settle();
      settle();
      `CHK(coreStall, 1'b0)
      wr(OFF_CONTROL, 32'h0000_0080);
      rd(8'h20, q);
      `CHK(q, 32'h0000_0000)
      rd(OFF_UNLOCK, q);
      `CHK(q, 32'h0000_0000)
      `CHK(pslverr, 1'b0)
   endtask : tMap
   initial begin
      reset = 1'b1;
      cfgAllow = 1'b1;
      timerEn = 1'b1;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      tPowerup();
      tWriteRead();
      tReject();
      tIrq();
      tMap();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
